//--- design/custom_instr_pkg.sv
package custom_instr_pkg;

  // Data path width of the hart
  localparam int XLEN = 64;

  // Base opcodes of the custom and system spaces
  localparam logic [6:0] OPC_CUSTOM0 = 7'h0b;
  localparam logic [6:0] OPC_SYSTEM = 7'h73;

  // Shift-left-immediate hints: rd = 0, rs1 = 0, shift amount in bits 25:20
  localparam logic [31:0] IHB_ENC = 32'h0010_1013;
  localparam logic [31:0] EHB_ENC_DEFAULT = 32'h0030_1013;
  localparam logic [31:0] PAUSE_ENC = 32'h0050_1013;

  // Conditional select and prefetch encodings (match under mask)
  localparam logic [31:0] CSEL_MATCH_DEFAULT = 32'h0000_100b;
  localparam logic [31:0] CSEL_MASK_DEFAULT = 32'h0600_707f;
  localparam logic [31:0] PREF_MATCH_DEFAULT = 32'h0000_000b;
  localparam logic [31:0] PREF_MASK_DEFAULT = 32'h0000_707f;

  // Load-pair fields
  localparam logic [2:0] PAIR_FUNCT3 = 3'h4;
  localparam logic [2:0] LDP_SEL = 3'h0;
  localparam logic [1:0] LWP_SEL = 2'h1;

  // Random translation write fields
  localparam logic [6:0] TLBWR_FUNCT7 = 7'h76;
  localparam logic [1:0] PRIV_MACHINE = 2'h3;
  localparam int PTE_G_BIT = 5;

  // Translation root select values
  localparam logic [1:0] ROOT_SATP = 2'h0;
  localparam logic [1:0] ROOT_VSATP = 2'h1;
  localparam logic [1:0] ROOT_HGATP = 2'h2;

  // Exception cause codes
  localparam logic [4:0] CAUSE_ILLEGAL = 5'h02;
  localparam logic [4:0] CAUSE_LOAD_MISALIGNED = 5'h04;

  // Atomicity class of a load-pair request
  localparam logic [1:0] ATOM_NONE = 2'h0;
  localparam logic [1:0] ATOM_HALF = 2'h1;
  localparam logic [1:0] ATOM_FULL = 2'h2;

  // Prefetch hint decoding
  localparam logic [2:0] PF_LOAD = 3'h0;
  localparam logic [2:0] PF_STORE = 3'h1;
  localparam logic [2:0] PF_PREP_STORE = 3'h7;
  localparam logic [1:0] CACHE_L1I = 2'h0;

  // Reset seed and default pause bound
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam int PAUSE_MAX_CYCLES_DEFAULT = 1024;

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EXEC_BAR,
    ST_FETCH_BAR,
    ST_LOAD_REQ,
    ST_LOAD_WAIT,
    ST_PAUSED
  } seq_state_type;

endpackage

//--- design/random_index_gen.sv
`timescale 1ns/1ps
// Free-running LFSR giving a pseudo-random buffer entry index
module random_index_gen #(
  parameter int INDEX_W = 6
) (
  input wire logic clk,
  input wire logic nrst,
  output logic [INDEX_W-1:0] index
);
  import custom_instr_pkg::*;

  // Maximal-length 16-bit Galois register
  logic [15:0] lfsr_q;

  // Steps every cycle so the pick depends on timing, not on call count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lfsr_q <= LFSR_SEED;
    end else begin
      lfsr_q <= {1'b0, lfsr_q[15:1]} ^ (lfsr_q[0] ? 16'hb400 : 16'h0000);
    end
  end

  assign index = lfsr_q[INDEX_W-1:0];
endmodule

//--- design/pause_timer.sv
`timescale 1ns/1ps
// Down counter bounding how long a hart may stay paused
module pause_timer #(
  parameter int MAX_CYCLES = 1024
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic run,
  output logic expired
);
  localparam int CNT_W = $clog2(MAX_CYCLES + 1);
  localparam logic [CNT_W-1:0] RELOAD = CNT_W'(MAX_CYCLES);

  // Remaining pause cycles
  logic [CNT_W-1:0] count_q;

  // Reload on every pause entry, count down while paused
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= RELOAD;
    end else if (run && count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign expired = run && (count_q == '0);
endmodule

//--- design/custom_instr_unit.sv
`timescale 1ns/1ps
// Behaviour
// - Select rs1 if rs2 nonzero, else rs3
// - Execution barrier waits out execution hazards
// - Fetch barrier makes later fetches see state
// - Custom ops trap illegal when enable clear
// - Pair address is rs1 plus unsigned offset
// - Doubleword pair: low then high half
// - Doubleword pair atomicity by alignment
// - Doubleword pair misaligned trap when configured
// - Word pair: two sign-extended words
// - Word pair atomicity by alignment
// - Word pair misaligned trap when configured
// - Equal destinations give unspecified value
// - Translation write needs walker and machine mode
// - Fill random entry from mtval, PTE, global
// - Non-leaf mode: level zero, config level
// - Root select: satp, vsatp, hgatp
// - Pause ends on flag, interrupt, timeout
// - Remote store clearing flag wakes waiter
// - Pause may be a plain no-op
// - Prefetch requests cache action at address
// - Hint bits 4:3 pick target cache
// - Hint bits 2:0 pick prefetch type
// - Prefetch never traps on address
module custom_instr_unit #(
  parameter logic [31:0] CSEL_MATCH = custom_instr_pkg::CSEL_MATCH_DEFAULT,
  parameter logic [31:0] CSEL_MASK = custom_instr_pkg::CSEL_MASK_DEFAULT,
  parameter logic [31:0] EHB_ENC = custom_instr_pkg::EHB_ENC_DEFAULT,
  parameter logic [31:0] PREF_MATCH = custom_instr_pkg::PREF_MATCH_DEFAULT,
  parameter logic [31:0] PREF_MASK = custom_instr_pkg::PREF_MASK_DEFAULT,
  parameter int PAUSE_MAX_CYCLES = custom_instr_pkg::PAUSE_MAX_CYCLES_DEFAULT,
  parameter bit PAUSE_IMPL = 1'b1,
  parameter int TLB_INDEX_W = 6
) (
  input wire logic clk,
  input wire logic nrst,
  // Issue side
  input wire logic instr_valid,
  output logic instr_ready,
  input wire logic [31:0] instr,
  input wire logic [custom_instr_pkg::XLEN-1:0] rs1_val,
  input wire logic [custom_instr_pkg::XLEN-1:0] rs2_val,
  input wire logic [custom_instr_pkg::XLEN-1:0] rs3_val,
  // Hart configuration and status
  input wire logic custom_enable,
  input wire logic [1:0] priv_level,
  input wire logic stw_implemented,
  input wire logic tlb_non_leaf,
  input wire logic pair_aligned,
  input wire logic virt_gva,
  input wire logic [1:0] cfg_level,
  input wire logic [1:0] cfg_root_sel,
  input wire logic cfg_global,
  input wire logic [custom_instr_pkg::XLEN-1:0] mtval,
  input wire logic reservation_held_flag,
  input wire logic interrupt_taken,
  // Completion and writeback
  output logic done,
  output logic wb_valid,
  output logic [4:0] wb_rd,
  output logic [custom_instr_pkg::XLEN-1:0] wb_data,
  output logic wb2_valid,
  output logic [4:0] wb2_rd,
  output logic [custom_instr_pkg::XLEN-1:0] wb2_data,
  output logic exc_valid,
  output logic [4:0] exc_cause,
  output logic [custom_instr_pkg::XLEN-1:0] exc_tval,
  // Hazard barriers
  output logic exec_barrier_req,
  output logic fetch_barrier_req,
  input wire logic barrier_done,
  // Load path
  output logic load_req_valid,
  input wire logic load_req_ready,
  output logic [custom_instr_pkg::XLEN-1:0] load_addr,
  output logic load_wide,
  output logic [1:0] load_atomic,
  input wire logic load_resp_valid,
  input wire logic [127:0] load_resp_data,
  // Translation buffer write
  output logic tlb_wr_valid,
  output logic [TLB_INDEX_W-1:0] tlb_wr_index,
  output logic [custom_instr_pkg::XLEN-1:0] tlb_wr_va,
  output logic [custom_instr_pkg::XLEN-1:0] tlb_wr_pte,
  output logic [1:0] tlb_wr_level,
  output logic [1:0] tlb_wr_root,
  // Prefetch request
  output logic pref_valid,
  output logic [custom_instr_pkg::XLEN-1:0] pref_addr,
  output logic [1:0] pref_cache,
  output logic [2:0] pref_type
);
  import custom_instr_pkg::*;

  // Sequencer state
  seq_state_type state_q;
  // Decode results
  logic is_csel, is_ehb, is_ihb, is_pause, is_ldp, is_lwp, is_tlbwr, is_pref;
  logic accept;
  logic illegal;
  logic misaligned;
  // Load-pair effective address and atomicity class
  logic [XLEN-1:0] pair_ea;
  logic [1:0] pair_atom;
  // Translation write fields
  logic [1:0] tw_level;
  logic [1:0] tw_root;
  // Prefetch effective address and action
  logic [XLEN-1:0] pref_ea;
  logic pref_act;
  // Destinations captured at issue
  logic [4:0] rd1_q, rd2_q;
  // Pause support and the translation write entry index
  logic pause_start, pause_end, timer_expired;
  logic [TLB_INDEX_W-1:0] rand_index;

  // Decode; hints need exact matches so plain shifts are untouched
  always_comb begin
    is_csel = (instr & CSEL_MASK) == CSEL_MATCH;
    is_ehb = instr == EHB_ENC;
    is_ihb = instr == IHB_ENC;
    is_pause = instr == PAUSE_ENC;
    is_ldp = instr[6:0] == OPC_CUSTOM0 && instr[14:12] == PAIR_FUNCT3 && instr[22:20] == LDP_SEL;
    is_lwp = instr[6:0] == OPC_CUSTOM0 && instr[14:12] == PAIR_FUNCT3 && instr[21:20] == LWP_SEL;
    is_tlbwr = {instr[31:23], instr[14:0]} == {TLBWR_FUNCT7, 2'h0, 3'h0, 5'h00, OPC_SYSTEM};
    is_pref = (instr & PREF_MASK) == PREF_MATCH && !is_ldp && !is_lwp;
  end

  // Address, alignment and atomicity for the pair loads
  always_comb begin
    pair_ea = rs1_val + (is_ldp ? {57'h0, instr[26:23], 3'h0} : {57'h0, instr[26:22], 2'h0});
    misaligned = 1'b0;
    pair_atom = ATOM_NONE;
    if (is_ldp) begin
      misaligned = pair_aligned && pair_ea[3:0] != 4'h0;
      pair_atom = pair_ea[3:0] == 4'h0 ? ATOM_FULL : pair_ea[2:0] == 3'h0 ? ATOM_HALF : ATOM_NONE;
    end else if (is_lwp) begin
      misaligned = pair_aligned && pair_ea[2:0] != 3'h0;
      pair_atom = pair_ea[2:0] == 3'h0 ? ATOM_FULL : pair_ea[1:0] == 2'h0 ? ATOM_HALF : ATOM_NONE;
    end
  end

  // Level and root selection for the translation write
  assign tw_level = tlb_non_leaf ? cfg_level : instr[21:20];
  assign tw_root = tlb_non_leaf ? cfg_root_sel : (virt_gva ? ROOT_VSATP : ROOT_SATP);

  // Illegal cases; the shift hints are ordinary shifts and never trap
  assign illegal = ((is_csel || is_ldp || is_lwp || is_pref) && !custom_enable)
    || (is_tlbwr && (!stw_implemented || priv_level != PRIV_MACHINE))
    || (is_tlbwr && tlb_non_leaf && (instr[22:20] != 3'h0 || cfg_root_sel > ROOT_HGATP));

  // Prefetch address and whether the hint asks for anything at all
  always_comb begin
    pref_ea = rs1_val + {{52{instr[31]}}, instr[31:20]};
    case (instr[9:7])
      PF_LOAD: pref_act = 1'b1;
      PF_STORE, PF_PREP_STORE: pref_act = instr[11:10] != CACHE_L1I;
      default: pref_act = 1'b0;
    endcase
  end

  assign accept = instr_valid && instr_ready;
  assign pause_start = accept && is_pause && PAUSE_IMPL;
  // Flag drops on a remote store to the lock, waking the waiter
  assign pause_end = !reservation_held_flag || interrupt_taken || timer_expired;
  assign instr_ready = state_q == ST_IDLE;

  // Sequencer for operations that take more than one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept && !illegal) begin
            if (is_ehb) begin
              state_q <= ST_EXEC_BAR;
            end else if (is_ihb) begin
              state_q <= ST_FETCH_BAR;
            end else if ((is_ldp || is_lwp) && !misaligned) begin
              state_q <= ST_LOAD_REQ;
            end else if (pause_start) begin
              state_q <= ST_PAUSED;
            end
          end
        end
        ST_EXEC_BAR, ST_FETCH_BAR: state_q <= barrier_done ? ST_IDLE : state_q;
        ST_LOAD_REQ: state_q <= load_req_ready ? ST_LOAD_WAIT : state_q;
        ST_LOAD_WAIT: state_q <= load_resp_valid ? ST_IDLE : state_q;
        ST_PAUSED: state_q <= pause_end ? ST_IDLE : state_q;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Barrier requests are levels that the unit holds until barrier_done
  assign exec_barrier_req = state_q == ST_EXEC_BAR;
  assign fetch_barrier_req = state_q == ST_FETCH_BAR;
  assign load_req_valid = state_q == ST_LOAD_REQ;

  // Load request fields captured at issue
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      load_addr <= '0;
      load_wide <= 1'b0;
      load_atomic <= ATOM_NONE;
      rd1_q <= 5'h00;
      rd2_q <= 5'h00;
    end else if (accept && (is_ldp || is_lwp)) begin
      load_addr <= pair_ea;
      load_wide <= is_ldp;
      load_atomic <= pair_atom;
      rd1_q <= instr[11:7];
      rd2_q <= instr[31:27];
    end
  end

  // Register writeback, from the select or from a load response
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_valid <= 1'b0;
      wb_rd <= 5'h00;
      wb_data <= '0;
      wb2_valid <= 1'b0;
      wb2_rd <= 5'h00;
      wb2_data <= '0;
    end else begin
      wb_valid <= 1'b0;
      wb2_valid <= 1'b0;
      if (accept && is_csel && !illegal) begin
        wb_valid <= 1'b1;
        wb_rd <= instr[11:7];
        wb_data <= (rs2_val != '0) ? rs1_val : rs3_val;
      end else if (state_q == ST_LOAD_WAIT && load_resp_valid) begin
        wb_valid <= 1'b1;
        wb_rd <= rd1_q;
        wb2_rd <= rd2_q;
        // Same destination: only the first write lands, value left loose
        wb2_valid <= rd1_q != rd2_q;
        if (load_wide) begin
          wb_data <= load_resp_data[63:0];
          wb2_data <= load_resp_data[127:64];
        end else begin
          wb_data <= {{32{load_resp_data[31]}}, load_resp_data[31:0]};
          wb2_data <= {{32{load_resp_data[63]}}, load_resp_data[63:32]};
        end
      end
    end
  end

  // Exceptions; a prefetch reports one only as illegal while the enable is clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      exc_valid <= 1'b0;
      exc_cause <= 5'h00;
      exc_tval <= '0;
    end else begin
      exc_valid <= 1'b0;
      if (accept && illegal) begin
        exc_valid <= 1'b1;
        exc_cause <= CAUSE_ILLEGAL;
        exc_tval <= {32'h0, instr};
      end else if (accept && (is_ldp || is_lwp) && misaligned) begin
        exc_valid <= 1'b1;
        exc_cause <= CAUSE_LOAD_MISALIGNED;
        exc_tval <= pair_ea;
      end
    end
  end

  // Completion pulse for every accepted instruction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      done <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: done <= accept && (illegal || misaligned || !(is_ehb || is_ihb || is_ldp || is_lwp || pause_start));
        ST_EXEC_BAR, ST_FETCH_BAR: done <= barrier_done;
        ST_LOAD_WAIT: done <= load_resp_valid;
        ST_PAUSED: done <= pause_end;
        default: done <= 1'b0;
      endcase
    end
  end

  // Translation buffer write, one pulse per legal instruction
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tlb_wr_valid <= 1'b0;
      tlb_wr_index <= '0;
      tlb_wr_va <= '0;
      tlb_wr_pte <= '0;
      tlb_wr_level <= 2'h0;
      tlb_wr_root <= ROOT_SATP;
    end else begin
      tlb_wr_valid <= accept && is_tlbwr && !illegal;
      if (accept && is_tlbwr && !illegal) begin
        tlb_wr_index <= rand_index;
        tlb_wr_va <= mtval;
        tlb_wr_pte <= rs1_val | (XLEN'(cfg_global) << PTE_G_BIT);
        tlb_wr_level <= tw_level;
        tlb_wr_root <= tw_root;
      end
    end
  end

  // Prefetch request; translation faults are dropped downstream, no trap
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pref_valid <= 1'b0;
      pref_addr <= '0;
      pref_cache <= CACHE_L1I;
      pref_type <= PF_LOAD;
    end else begin
      pref_valid <= accept && is_pref && !illegal && pref_act;
      if (accept && is_pref && !illegal) begin
        pref_addr <= pref_ea;
        pref_cache <= instr[11:10];
        pref_type <= instr[9:7];
      end
    end
  end

  // Entry picker for the translation write
  random_index_gen #(
    .INDEX_W(TLB_INDEX_W)
  ) u_rand (
    .clk(clk),
    .nrst(nrst),
    .index(rand_index)
  );

  // Pause bound, reloaded whenever a pause begins
  pause_timer #(
    .MAX_CYCLES(PAUSE_MAX_CYCLES)
  ) u_pause_timer (
    .clk(clk),
    .nrst(nrst),
    .load(pause_start),
    .run(state_q == ST_PAUSED),
    .expired(timer_expired)
  );

endmodule

//--- sim/custom_instr_unit_asserts.sv
`timescale 1ns/1ps
// Port-level checks of the custom instruction unit
module custom_instr_unit_asserts
  import custom_instr_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic [31:0] instr,
  input wire logic [63:0] rs1_val,
  input wire logic [63:0] rs2_val,
  input wire logic [63:0] rs3_val,
  input wire logic custom_enable,
  input wire logic [1:0] priv_level,
  input wire logic done,
  input wire logic [63:0] wb_data,
  input wire logic exc_valid,
  input wire logic [4:0] exc_cause,
  input wire logic exec_barrier_req,
  input wire logic fetch_barrier_req,
  input wire logic barrier_done,
  input wire logic load_req_valid,
  input wire logic load_req_ready,
  input wire logic [63:0] load_addr,
  input wire logic load_wide,
  input wire logic [1:0] load_atomic,
  input wire logic load_resp_valid,
  input wire logic [127:0] load_resp_data,
  input wire logic tlb_wr_valid
);
  logic take; // Instruction accepted at this edge
  logic is_sel; // Word decodes as conditional select
  logic is_stw; // Word decodes as translation write
  assign take = instr_valid && instr_ready;
  assign is_sel = (instr & CSEL_MASK_DEFAULT) == CSEL_MATCH_DEFAULT;
  assign is_stw = instr[6:0] == OPC_SYSTEM && instr[31:23] == {TLBWR_FUNCT7, 2'h0} && instr[14:7] == 8'h00;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_select_pick: assert property (
    take && is_sel && custom_enable && instr[11:7] != 5'h00 |=>
      done && wb_data == ($past(rs2_val) != 64'h0 ? $past(rs1_val) : $past(rs3_val)))
    else $error("select result wrong");
  a_enable_trap: assert property (
    take && is_sel && !custom_enable |=> done && exc_valid && exc_cause == CAUSE_ILLEGAL)
    else $error("disabled select did not trap");
  a_barrier_hold: assert property (
    exec_barrier_req && !barrier_done |=> exec_barrier_req && !instr_ready)
    else $error("barrier dropped early");
  a_barrier_end: assert property (
    (exec_barrier_req || fetch_barrier_req) && barrier_done |=> done && !exec_barrier_req && !fetch_barrier_req)
    else $error("barrier did not finish");
  a_fetch_start: assert property (
    take && instr == IHB_ENC |=> fetch_barrier_req && !instr_ready)
    else $error("fetch barrier not raised");
  // Atomicity class follows the low address bits of the pair
  a_pair_atomic: assert property (
    load_req_valid |-> load_atomic == (load_wide ?
      (load_addr[3:0] == 4'h0 ? ATOM_FULL : load_addr[2:0] == 3'h0 ? ATOM_HALF : ATOM_NONE) :
      (load_addr[2:0] == 3'h0 ? ATOM_FULL : load_addr[1:0] == 2'h0 ? ATOM_HALF : ATOM_NONE)))
    else $error("atomicity class wrong");
  a_load_hold: assert property (
    load_req_valid && !load_req_ready |=> load_req_valid && $stable(load_addr))
    else $error("load request not held");
  a_pair_low: assert property (
    load_resp_valid && load_wide |=> done && wb_data == $past(load_resp_data[63:0]))
    else $error("pair low half wrong");
  a_tlb_priv: assert property (
    take && is_stw && priv_level != PRIV_MACHINE |=> exc_valid && exc_cause == CAUSE_ILLEGAL && !tlb_wr_valid)
    else $error("translation write below machine level");
  a_pause_stop: assert property (
    take && instr == PAUSE_ENC |=> !instr_ready)
    else $error("pause kept issuing");
endmodule

bind custom_instr_unit custom_instr_unit_asserts u_asserts (.*);

//--- sim/lsu_partner.sv
`timescale 1ns/1ps
// Load-store and hazard side of the hart, with a settable lag
module lsu_partner (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [2:0] lag,
  input wire logic load_req_valid,
  input wire logic [63:0] load_addr,
  input wire logic exec_barrier_req,
  input wire logic fetch_barrier_req,
  output logic load_req_ready,
  output logic load_resp_valid,
  output logic [127:0] load_resp_data,
  output logic barrier_done
);
  logic [2:0] cnt_q; // Cycles spent on the open request
  logic busy_q; // Load accepted, answer still owed
  logic [63:0] addr_q; // Address of the accepted load
  logic due; // Lag used up
  logic bar; // Either barrier open
  assign due = cnt_q >= lag;
  assign bar = exec_barrier_req || fetch_barrier_req;
  // Accept late, so the unit has to hold its request
  assign load_req_ready = load_req_valid && !busy_q && due;
  // One answer carries the whole pair, low bytes first
  assign load_resp_valid = busy_q && due;
  // Idle data is inverted so a stale capture never matches
  assign load_resp_data = load_resp_valid ? {~addr_q, addr_q} : {addr_q, ~addr_q};
  // Hazards drained once the lag runs out
  assign barrier_done = bar && due;
  // Lag counter and load tracking
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 3'h0;
      busy_q <= 1'b0;
      addr_q <= 64'h0;
    end else if (load_req_ready || load_resp_valid || barrier_done) begin
      cnt_q <= 3'h0;
      busy_q <= load_req_ready;
      if (load_req_ready) begin
        addr_q <= load_addr;
      end
    end else if (load_req_valid || busy_q || bar) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ps
// Issue-side bench for the custom instruction unit
module testbench;
  import custom_instr_pkg::*;
  localparam logic [31:0] CS = {5'd3, 2'h0, 5'd2, 5'd1, 3'h1, 5'd5, OPC_CUSTOM0}; // Select word
  localparam logic [31:0] LD = {5'd7, 4'h2, LDP_SEL, 5'd1, PAIR_FUNCT3, 5'd6, OPC_CUSTOM0}; // Pair offset 16
  localparam logic [31:0] LW = {5'd7, 5'h03, LWP_SEL, 5'd1, PAIR_FUNCT3, 5'd6, OPC_CUSTOM0}; // Pair offset 12
  localparam logic [63:0] LB [8] = '{64'h1000, 64'h1008, 64'h1004, 64'h1008, 64'hffff_fff0_7fff_fffc,
    64'hffff_fff0_7fff_fff8, 64'hffff_fff0_7fff_fffa, 64'hffff_fff0_7fff_fff8};
  localparam logic [1:0] LA [8] = '{ATOM_FULL, ATOM_HALF, ATOM_NONE, ATOM_HALF, ATOM_FULL, ATOM_HALF, ATOM_NONE,
    ATOM_HALF};
  logic clk, nrst, instr_valid, custom_enable, stw_implemented, tlb_non_leaf, pair_aligned, virt_gva;
  logic cfg_global, reservation_held_flag, interrupt_taken, instr_ready, done, wb_valid, wb2_valid, exc_valid;
  logic exec_barrier_req, fetch_barrier_req, barrier_done, load_req_valid, load_req_ready, load_wide;
  logic load_resp_valid, tlb_wr_valid, pref_valid;
  logic [31:0] instr;
  logic [63:0] rs1_val, rs2_val, rs3_val, mtval, wb_data, wb2_data, exc_tval, load_addr, tlb_wr_va, tlb_wr_pte;
  logic [63:0] pref_addr, va;
  logic [127:0] load_resp_data;
  logic [1:0] priv_level, cfg_level, cfg_root_sel, load_atomic, tlb_wr_level, tlb_wr_root, pref_cache;
  logic [4:0] wb_rd, wb2_rd, exc_cause;
  logic [2:0] pref_type, lag;
  // Values captured during the wait and in the completion cycle
  logic r_wbv, r_wb2v, r_exc, r_tlbv, r_pv, r_eb, r_fb, r_wide, ok;
  logic [63:0] r_wb, r_wb2, r_tval, r_la, r_va, r_pte, r_pa;
  logic [4:0] r_rd, r_rd2, r_cause;
  logic [1:0] r_at, r_lvl, r_root, r_pc;
  logic [2:0] r_pt;
  int r_lat, error_cnt, checked;

  custom_instr_unit #(.PAUSE_MAX_CYCLES(8)) dut (.tlb_wr_index(), .*);
  lsu_partner u_partner (.*);

  // Core clock, 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [63:0] sx(input logic [31:0] w);
    return {{32{w[31]}}, w};
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_in(input int got, input int lo, input int hi);
    checked++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("unexpected %0t latency %0d", $time, got);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Issue one word, then wait a bounded time for completion
  task automatic run(input logic [31:0] i, input logic [63:0] a, input logic [63:0] b, input logic [63:0] c);
    @(posedge clk);
    instr_valid <= 1'b1;
    {instr, rs1_val, rs2_val, rs3_val} <= {i, a, b, c};
    @(posedge clk);
    instr_valid <= 1'b0;
    {r_eb, r_fb, r_lat, r_la} = '0;
    while (r_lat < 200) begin
      @(posedge clk);
      r_lat++;
      r_eb |= exec_barrier_req;
      r_fb |= fetch_barrier_req;
      if (load_req_valid === 1'b1) {r_la, r_wide, r_at} = {load_addr, load_wide, load_atomic};
      if (done === 1'b1) break;
    end
    if (r_lat >= 200) begin
      error_cnt++;
      $display("unexpected %0t no completion", $time);
      wrap_up();
    end
    {r_wbv, r_rd, r_wb, r_wb2v, r_rd2, r_wb2} = {wb_valid, wb_rd, wb_data, wb2_valid, wb2_rd, wb2_data};
    {r_exc, r_cause, r_tval} = {exc_valid, exc_cause, exc_tval};
    {r_tlbv, r_va, r_pte, r_lvl, r_root} = {tlb_wr_valid, tlb_wr_va, tlb_wr_pte, tlb_wr_level, tlb_wr_root};
    {r_pv, r_pa, r_pc, r_pt} = {pref_valid, pref_addr, pref_cache, pref_type};
  endtask

  initial begin
    {instr_valid, stw_implemented, tlb_non_leaf, pair_aligned, virt_gva, cfg_global, interrupt_taken} = '0;
    {custom_enable, reservation_held_flag, priv_level, cfg_level, cfg_root_sel, lag} = {2'b11, 2'h3, 7'h0};
    {instr, rs1_val, rs2_val, rs3_val, mtval} = '0;
    {error_cnt, checked} = '0;
    nrst = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    // Select on nonzero high bits, then on zero
    for (int k = 0; k < 2; k++) begin
      run(CS, 64'haaaa, k ? 64'h0 : 64'h1_0000_0000, 64'h5555);
      chk(r_wb, k ? 64'h5555 : 64'haaaa);
      chk({r_wbv, r_rd}, {1'b1, 5'd5});
    end
    // Gated words trap while the enable is clear
    custom_enable <= 1'b0;
    for (int j = 0; j < 3; j++) begin
      run(j == 0 ? CS : j == 1 ? LD : 32'hff00_800b, 64'h1000, 64'h1, 64'h0);
      chk(r_exc, 1'b1);
      chk(r_cause, CAUSE_ILLEGAL);
      chk(r_pv, 1'b0);
    end
    custom_enable <= 1'b1;
    $display("test select and enable done");
    // Pair loads over every alignment class, slow partner too
    for (int i = 0; i < 8; i++) begin
      lag <= {1'b0, i[1:0]};
      pair_aligned <= i % 4 == 3;
      va = LB[i] + (i < 4 ? 64'd16 : 64'd12);
      run(i < 4 ? LD : LW, LB[i], 64'h0, 64'h0);
      if (i % 4 == 3) begin
        chk(r_exc, 1'b1);
        chk(r_cause, CAUSE_LOAD_MISALIGNED);
        chk(r_tval, va);
      end else begin
        chk(r_la, va);
        chk(r_wide, i < 4);
        chk(r_at, LA[i]);
        chk(r_wb, i < 4 ? va : sx(va[31:0]));
        chk(r_wb2, i < 4 ? ~va : sx(va[63:32]));
        chk({r_wb2v, r_rd, r_rd2}, {1'b1, 5'd6, 5'd7});
      end
    end
    pair_aligned <= 1'b0;
    // Equal destinations: only the first write lands
    run({5'd6, LD[26:0]}, 64'h1000, 64'h0, 64'h0);
    chk({r_wbv, r_wb2v}, 2'b10);
    $display("test pair loads done");
    // Both barriers hold issue until the hazards drain
    for (int k = 0; k < 2; k++) begin
      lag <= 3'h3;
      run(k ? IHB_ENC : EHB_ENC_DEFAULT, 64'h0, 64'h0, 64'h0);
      chk(r_eb, k == 0);
      chk(r_fb, k == 1);
      chk_in(r_lat, 5, 8);
    end
    $display("test barriers done");
    // Translation write: legal, refused and every root select
    mtval <= 64'h0000_7fff_0000_1000;
    for (int i = 0; i < 8; i++) begin
      ok = !(i inside {1, 2, 3, 7});
      stw_implemented <= i != 1;
      priv_level <= i == 2 ? 2'h1 : PRIV_MACHINE;
      tlb_non_leaf <= i >= 3;
      virt_gva <= i == 0;
      {cfg_level, cfg_root_sel, cfg_global} <= {2'h1, i[1:0], i[0]};
      run({TLBWR_FUNCT7, 2'h0, i == 0 ? 3'h2 : i == 3 ? 3'h1 : 3'h0, 5'd1, 8'h0, OPC_SYSTEM}, 64'h1234_5401, 0, 0);
      chk(r_exc, !ok);
      chk(r_tlbv, ok);
      if (ok) begin
        chk(r_va, 64'h0000_7fff_0000_1000);
        chk(r_pte, 64'h1234_5401 | (64'(i[0]) << PTE_G_BIT));
        chk(r_lvl, i == 0 ? 2'h2 : 2'h1);
        chk(r_root, i == 0 ? ROOT_VSATP : i[1:0]);
      end
    end
    $display("test translation write done");
    // Pause wakes on flag, interrupt, or timer twice
    for (int k = 0; k < 4; k++) begin
      reservation_held_flag <= k != 0;
      interrupt_taken <= k == 1;
      run(PAUSE_ENC, 64'h0, 64'h0, 64'h0);
      if (k < 2) chk_in(r_lat, 1, 3);
      else chk_in(r_lat, 8, 12);
    end
    interrupt_taken <= 1'b0;
    $display("test pause done");
    // Every hint code at a negative offset
    for (int h = 0; h < 32; h++) begin
      ok = h[2:0] == PF_LOAD || (h[2:0] inside {PF_STORE, PF_PREP_STORE} && h[4:3] != CACHE_L1I);
      run({12'hff0, 5'd1, 3'h0, h[4:0], OPC_CUSTOM0}, 64'h2000, 64'h0, 64'h0);
      chk(r_pv, ok);
      chk(r_exc, 1'b0);
      if (ok) chk(r_pa, 64'h1ff0);
      if (ok) chk({r_pc, r_pt}, h[4:0]);
    end
    $display("test prefetch done");
    wrap_up();
  end
endmodule
